// ---- verilog/ipg_params.svh ----
// index pulse gating: register offsets, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef IPG_PARAMS_SVH
`define IPG_PARAMS_SVH
`define IPG_CFG_ADDR        16'h0885
`define IPG_CFG_RESET       8'h40
`define IPG_GATE_LSB        0
`define IPG_GATE_MSB        1
`define IPG_SE_BIT          3
`define IPG_LNM_BIT         6
`define IPG_CFG_WMASK       8'h4B
`endif

// ---- verilog/ipg_pkg.sv ----
// index pulse gating: shared types
// assumes ipg_params.svh defines the field constants
package ipg_pkg;
	typedef enum logic [1:0] {
		IPG_GATE_NONE,
		IPG_GATE_A,
		IPG_GATE_B,
		IPG_GATE_AB
	} ipg_gate_t;
endpackage

// ---- verilog/ipg_edge.sv ----
// rise and fall detector for one synchronous quadrature level
// assumes input is synchronous to sys_clk
`timescale 1ns/1ps
module ipg_edge (
	input  wire logic sys_clk,
	input  wire logic reset,
	input  wire logic level,
	output logic      rise,
	output logic      fall
);
	typedef struct packed {
		logic prev;
	} ipg_edge_state_t;
	ipg_edge_state_t s_q, s_d;

	always_comb begin
		s_d      = s_q;
		s_d.prev = level;
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// an edge flags in the first cycle that samples the new level
	assign rise = level & ~s_q.prev;
	assign fall = ~level & s_q.prev;
endmodule // ipg_edge

// ---- verilog/ipg_top.sv ----
// index pulse gating: once-per-revolution index pulse with quadrature gating
// assumes z_above, quad_a_out, quad_b_out synchronous to sys_clk;
// register port is a simple synchronous write/read strobe pair
//
// Contract
// - positive index output is low except one high pulse per revolution
// - differential mode: negative output is inverse of positive output
// - single_ended_select 0 drives both; 1 releases negative output
// - gate 00: positive output follows Z+ greater than Z- directly
// - gate 01: rise at A fall after Z, fall at next A rise
// - gate 10: rise at B fall after Z, fall at next B rise
// - gate 11: rise at A fall with B low or vice versa
// - gating assumes Z difference positive, quadrature difference negative
// - index config register selects output style and pulse timing
`timescale 1ns/1ps
`include "ipg_params.svh"
module ipg_top (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        z_above,
	input  wire logic        quad_a_out,
	input  wire logic        quad_b_out,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [15:0] cfg_addr,
	input  wire logic [7:0]  cfg_wdata,
	output logic      [7:0]  cfg_rdata,
	output logic             index_out_pos,
	output logic             index_out_neg_o,
	output logic             index_out_neg_oe,
	output logic             low_noise_select
);
	////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_PULSE,
		ST_WAIT_Z_LOW
	} ipg_state_t;

	typedef struct packed {
		logic [7:0]  cfg;
		ipg_state_t  st;
		logic        pos;
		logic        neg_o;
		logic        neg_oe;
		logic [7:0]  rdata;
	} ipg_top_state_t;

	ipg_top_state_t s_q, s_d;

	logic a_rise, a_fall, b_rise, b_fall;

	ipg_edge u_edge_a (
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (quad_a_out),
		.rise    (a_rise),
		.fall    (a_fall)
	);
	ipg_edge u_edge_b (
		.sys_clk (sys_clk),
		.reset   (reset),
		.level   (quad_b_out),
		.rise    (b_rise),
		.fall    (b_fall)
	);

	function automatic ipg_pkg::ipg_gate_t gate_of(input logic [7:0] c);
		return ipg_pkg::ipg_gate_t'(c[`IPG_GATE_MSB:`IPG_GATE_LSB]);
	endfunction

	ipg_pkg::ipg_gate_t gate;
	logic start_ev, stop_ev, pos_next, cfg_hit;
	assign gate    = gate_of(s_q.cfg);
	assign cfg_hit = (cfg_addr == `IPG_CFG_ADDR);

	////////////////////////////////////////////////////////////////////
	// gated start and stop edges per mode; polarity fixed as documented
	always_comb begin
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		unique case (gate)
			ipg_pkg::IPG_GATE_NONE: begin
				start_ev = 1'b0;
				stop_ev  = 1'b0;
			end
			ipg_pkg::IPG_GATE_A: begin
				start_ev = a_fall;
				stop_ev  = a_rise;
			end
			ipg_pkg::IPG_GATE_B: begin
				start_ev = b_fall;
				stop_ev  = b_rise;
			end
			ipg_pkg::IPG_GATE_AB: begin
				start_ev = (a_fall & ~quad_b_out) |
					(b_fall & ~quad_a_out);
				stop_ev  = a_rise | b_rise;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_comb begin
		s_d      = s_q;
		pos_next = 1'b0;
		if (cfg_wr && cfg_hit) begin
			// reserved bits stay zero
			s_d.cfg = cfg_wdata & `IPG_CFG_WMASK;
		end
		s_d.rdata = (cfg_rd && cfg_hit) ? s_q.cfg : 8'h00;
		if (gate == ipg_pkg::IPG_GATE_NONE) begin
			s_d.st   = ST_IDLE;
			pos_next = z_above;
		end else begin
			unique case (s_q.st)
				ST_IDLE: begin
					if (z_above) begin
						s_d.st = start_ev ? ST_PULSE : ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (start_ev) begin
						s_d.st = ST_PULSE;
					end else if (!z_above) begin
						s_d.st = ST_IDLE;
					end
				end
				ST_PULSE: begin
					// held regardless of z until the stop edge
					if (stop_ev) begin
						s_d.st = z_above ? ST_WAIT_Z_LOW : ST_IDLE;
					end
				end
				ST_WAIT_Z_LOW: begin
					// one pulse per index window only
					if (!z_above) begin
						s_d.st = ST_IDLE;
					end
				end
			endcase
			pos_next = (s_d.st == ST_PULSE);
		end
		s_d.pos    = pos_next;
		s_d.neg_o  = ~pos_next;
		s_d.neg_oe = ~s_d.cfg[`IPG_SE_BIT];
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_q        <= '0;
			s_q.cfg    <= `IPG_CFG_RESET;
			s_q.st     <= ST_IDLE;
			s_q.neg_o  <= 1'b1;
			s_q.neg_oe <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign index_out_pos    = s_q.pos;
	assign index_out_neg_o  = s_q.neg_o;
	assign index_out_neg_oe = s_q.neg_oe;
	assign cfg_rdata        = s_q.rdata;
	// software is expected to keep this bit set
	assign low_noise_select = s_q.cfg[`IPG_LNM_BIT];

	////////////////////////////////////////////////////////////////////
	// antecedents pair the registered state with the live edge flags,
	// so each consequence lands one cycle after the qualifying sample
	sequence s_a_start;
		gate == ipg_pkg::IPG_GATE_A && s_q.st == ST_ARMED && a_fall;
	endsequence
	sequence s_a_stop;
		gate == ipg_pkg::IPG_GATE_A && s_q.st == ST_PULSE && a_rise;
	endsequence
	sequence s_b_start;
		gate == ipg_pkg::IPG_GATE_B && s_q.st == ST_ARMED && b_fall;
	endsequence
	sequence s_b_stop;
		gate == ipg_pkg::IPG_GATE_B && s_q.st == ST_PULSE && b_rise;
	endsequence
	sequence s_ab_start_a;
		gate == ipg_pkg::IPG_GATE_AB && s_q.st == ST_ARMED &&
		a_fall && !quad_b_out;
	endsequence
	sequence s_ab_start_b;
		gate == ipg_pkg::IPG_GATE_AB && s_q.st == ST_ARMED &&
		b_fall && !quad_a_out;
	endsequence
	sequence s_ab_stop;
		gate == ipg_pkg::IPG_GATE_AB && s_q.st == ST_PULSE &&
		(a_rise || b_rise);
	endsequence

	a_neg_inverse: assert property (
		@(posedge sys_clk) disable iff (reset)
		index_out_neg_o == !index_out_pos)
		else $error("negative output not inverse of positive");
	a_single_ended: assert property (
		@(posedge sys_clk) disable iff (reset)
		(cfg_wr && cfg_hit) |=>
		index_out_neg_oe == !$past(cfg_wdata[`IPG_SE_BIT]))
		else $error("negative enable does not follow select bit");
	a_ungated_follow: assert property (
		@(posedge sys_clk) disable iff (reset)
		(gate == ipg_pkg::IPG_GATE_NONE && $stable(gate))
		|=> index_out_pos == $past(z_above))
		else $error("ungated output does not follow z");
	a_gate_a_rise: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_a_start |=> index_out_pos)
		else $error("gate a pulse did not start");
	a_gate_a_fall: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_a_stop |=> !index_out_pos)
		else $error("gate a pulse did not end");
	a_gate_b_rise: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_b_start |=> index_out_pos)
		else $error("gate b pulse did not start");
	a_gate_b_fall: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_b_stop |=> !index_out_pos)
		else $error("gate b pulse did not end");
	a_gate_ab_rise: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_ab_start_a |=> index_out_pos)
		else $error("gate ab pulse did not start on a");
	a_ab_b_rise: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_ab_start_b |=> index_out_pos)
		else $error("gate ab pulse did not start on b");
	a_gate_ab_fall: assert property (
		@(posedge sys_clk) disable iff (reset)
		s_ab_stop |=> !index_out_pos)
		else $error("gate ab pulse did not end");
	a_pulse_held: assert property (
		@(posedge sys_clk) disable iff (reset)
		(s_q.st == ST_PULSE && !stop_ev && gate != ipg_pkg::IPG_GATE_NONE
		&& !(cfg_wr && cfg_hit)) |=> index_out_pos)
		else $error("gated pulse dropped early");
	// after a pulse the window must close before another may start
	a_one_pulse: assert property (
		@(posedge sys_clk) disable iff (reset)
		(gate != ipg_pkg::IPG_GATE_NONE && s_q.st == ST_WAIT_Z_LOW)
		|=> !index_out_pos)
		else $error("second pulse in one index window");
	a_cfg_readback: assert property (
		@(posedge sys_clk) disable iff (reset)
		(cfg_rd && cfg_hit) |=> cfg_rdata == $past(s_q.cfg))
		else $error("config readback wrong");
endmodule // ipg_top

// ---- dv/ipg_ctr_model.sv ----
// counter-side model of the index input pair
// assumes the negative line has no pull resistor when released
`timescale 1ns/1ps
module ipg_ctr_model (
	input  wire logic sys_clk,
	input  wire logic neg_o,
	input  wire logic neg_oe,
	output logic      neg_wire
);
	logic last_q = 1'b0;
	// a floating line toggles so a stale level never reads as driven
	assign neg_wire = neg_oe ? neg_o : ~last_q;
	always @(posedge sys_clk) begin
		last_q <= neg_wire;
	end
endmodule // ipg_ctr_model

// ---- dv/test_index_pulse_gating.sv ----
// bench for ipg_top: random quadrature and index stimulus, cycle reference
// assumes ipg_ctr_model resolves the negative index line
`timescale 1ns/1ps
module test_index_pulse_gating;
	logic sys_clk = 0, reset = 1, z_above = 0, quad_a_out = 0, quad_b_out = 0;
	logic cfg_wr = 0, cfg_rd = 0, neg_wire, index_out_pos, index_out_neg_o;
	logic [15:0] cfg_addr = 16'h0000;
	logic [7:0] cfg_wdata = 8'h00, cfg_rdata;
	logic index_out_neg_oe, low_noise_select, pa = 0, pb = 0, exp_pos, done;
	logic [1:0] gate = 2'h0;
	int errors = 0, total_checks = 0, q = 0;
	ipg_top i_dut (.sys_clk(sys_clk), .reset(reset), .z_above(z_above),
		.quad_a_out(quad_a_out), .quad_b_out(quad_b_out), .cfg_wr(cfg_wr),
		.cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .index_out_pos(index_out_pos),
		.index_out_neg_o(index_out_neg_o),
		.index_out_neg_oe(index_out_neg_oe),
		.low_noise_select(low_noise_select));
	ipg_ctr_model i_ctr (.sys_clk(sys_clk), .neg_o(index_out_neg_o),
		.neg_oe(index_out_neg_oe), .neg_wire(neg_wire));
	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////////////////////////////////////
	// reference: a start edge counts while z is high or was high a cycle
	// ago (armed); stop edge ends; no new pulse until z drops
	always @(posedge sys_clk) begin : ref_model
		logic st, sp, fa, fb, zp;
		fa = pa & ~quad_a_out;
		fb = pb & ~quad_b_out;
		st = gate == 2'h1 ? fa : gate == 2'h2 ? fb :
			(fa & ~quad_b_out) | (fb & ~quad_a_out);
		sp = gate == 2'h1 ? ~pa & quad_a_out : gate == 2'h2 ?
			~pb & quad_b_out : (~pa & quad_a_out) | (~pb & quad_b_out);
		pa <= quad_a_out;
		pb <= quad_b_out;
		zp <= z_above;
		if (reset) begin
			exp_pos <= 1'b0;
			done <= 1'b0;
		end else if (gate == 2'h0) exp_pos <= z_above;
		else if (exp_pos & sp) begin
			exp_pos <= 1'b0;
			done <= z_above;
		end else if (~exp_pos & st & (z_above | zp) & ~done)
			exp_pos <= 1'b1;
		else if (~exp_pos & ~z_above) done <= 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	task report_and_stop;
		if (errors == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk_reg(input logic [7:0] g, input logic [7:0] e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task chk_pin(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wr(input logic [15:0] ad, input logic [7:0] d);
		@(posedge sys_clk);
		cfg_wr <= 1'b1;
		cfg_addr <= ad;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_wr <= 1'b0;
	endtask
	task rdc(input logic [15:0] ad, input logic [7:0] e);
		@(posedge sys_clk);
		cfg_rd <= 1'b1;
		cfg_addr <= ad;
		@(posedge sys_clk);
		cfg_rd <= 1'b0;
		@(negedge sys_clk);
		chk_reg(cfg_rdata, e);
	endtask
	// the tail of each run drops z and steps forward so any pulse ends
	task run(input logic [1:0] g, input logic s, input int n);
		wr(16'h0885, {2'b01, 2'b00, s, 1'b0, g});
		// the new mode reaches the reference one edge later, as in the design
		gate <= g;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk);
			if (i >= n - 8) z_above <= 1'b0;
			else if ($urandom % 16 == 0) z_above <= ~z_above;
			q = q + ((i >= n - 8) ? 1 : int'($urandom % 3) - 1);
			quad_a_out <= q[1];
			quad_b_out <= q[1] ^ q[0];
			@(negedge sys_clk);
			chk_pin(index_out_pos, exp_pos);
			chk_pin(index_out_neg_oe, ~s);
			if (!s) chk_pin(neg_wire, ~index_out_pos);
		end
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		report_and_stop;
	end
	initial begin
		void'($urandom(32'hBEA7));
		repeat (20) @(posedge sys_clk);
		reset <= 1'b0;
		rdc(16'h0885, 8'h40);
		rdc(16'h0886, 8'h00);
		wr(16'h0885, 8'hFF);
		wr(16'h0884, 8'h00);
		rdc(16'h0885, 8'h4B);
		chk_pin(low_noise_select, 1'b1);
		for (int k = 0; k < 8; k++) run(k[2:1], k[0], 600);
		report_and_stop;
	end
endmodule // test_index_pulse_gating
